// *** design/mrd_map.svh ***
/*
  Constants for the mode-dependent register default block.
  Assumes inclusion by bare name from design files.
*/
`ifndef MRD_MAP_SVH
`define MRD_MAP_SVH
`define MRD_MODE_OFF_VAL 3'h4
`define MRD_MODE_STBY_VAL 3'h4
`define MRD_MODE_NORM_VAL 3'h7
`define MRD_MODE_SLEEP_VAL 3'h1
`define MRD_MODE_RESET_VAL 3'h4
`define MRD_RSRC_OTEMP 5'h12
`define MRD_RSRC_RST 5'h00
`define MRD_WDP_RST 4'h4
`define MRD_RCC_LIMP 2'h3
`define MRD_RCC_RST 2'h0
`define MRD_DM_RST 56'hff_ffff_ffff_ffff
`define MRD_ID_RST 29'h0000_0000
`define MRD_CRC_RST 8'h00
`define MRD_GPM_RST 32'h0000_0000
`define MRD_DLC_RST 4'h0
`define MRD_LIMP_DELAY_MS 1000
`define MRD_CLK_MHZ 100
`define MRD_LIMP_CYCLES (`MRD_LIMP_DELAY_MS * 1000 * `MRD_CLK_MHZ)
`endif

// *** design/mrd_pkg.sv ***
/*
  Types for the mode-dependent register default block.
  Assumes the map header provides numeric constants.
*/
package mrd_pkg;
  typedef enum logic [2:0] {
    MRD_OFF = 3'h0,
    MRD_STANDBY = 3'h1,
    MRD_NORMAL = 3'h2,
    MRD_SLEEP = 3'h3,
    MRD_OVERTEMP = 3'h4,
    MRD_RESET = 3'h5
  } mrd_mode_e;
endpackage

// *** design/mrd_sync.sv ***
/*
  Two-stage synchroniser for a bundle of pin levels.
  Assumes one clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module mrd_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// *** design/mrd_limp_timer.sv ***
/*
  Limp delay timer: counts cycles spent in overtemp or reset mode.
  Assumes the limp count parameter sets the elapse point.
*/
`timescale 1ns/1ps
module mrd_limp_timer #(
  parameter int unsigned LIMP_CYCLES = 100000000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic elapsed_o
);
  logic [31:0] cnt_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_reg <= 32'h0;
      elapsed_o <= 1'b0;
    end else if (cnt_reg < LIMP_CYCLES) begin
      cnt_reg <= cnt_reg + 32'h1;
      elapsed_o <= (cnt_reg + 32'h1 >= LIMP_CYCLES);
    end
  end
endmodule

// *** design/mrd_regs.sv ***
/*
  Mode-dependent register defaults: updates control and status bits on
  every operating mode entry. Assumes mode request and host writes come from
  logic on the same clock; live status levels come from pins and are
  synchronised. Nonvolatile values are stable levels from the store.
*/
`timescale 1ns/1ps
`include "mrd_map.svh"

// Operation
// - mode field values per operating mode, kept unchanged on overtemp entry
// - reset counter increments on each reset entry
// - reset source loads overtemp or cause code
// - watchdog period restored on overtemp, reset
// - limp home set by delay or counter
// - transceiver status live only in normal
// - normal mode status clears entering normal
// - power-on flag set entering off mode
// - system event enable one after power-on
// - data mask bytes all ones at power-on
// - data mask enable one at power-on
// - live status zero in off, else live
// - error counter, program status always live
// - nonvolatile controls always show stored value
// - event flags and enables clear at power-on
// - crc, memory, identifier, length cleared at power-on
// - config valid, fd tolerance cleared at power-on
// - mode change discards host access in progress
module mrd_regs #(
  parameter int unsigned LIMP_CYCLES = `MRD_LIMP_CYCLES
) (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic [2:0] MODE_I,
  input wire logic [4:0] RESET_CAUSE_I,
  input wire logic TRX_ACTIVE_I,
  input wire logic [3:0] LIVE_STATUS_I,
  input wire logic [1:0] ALWAYS_LIVE_I,
  input wire logic [3:0] NV_CTRL_I,
  input wire logic WR_EN_I,
  input wire logic [3:0] WR_SEL_I,
  input wire logic [63:0] WR_DATA_I,
  output logic [2:0] OP_MODE_FIELD_O,
  output logic [1:0] RESET_COUNTER_O,
  output logic [4:0] RESET_SOURCE_CODE_O,
  output logic [3:0] WATCHDOG_PERIOD_SEL_O,
  output logic LIMP_HOME_CTRL_O,
  output logic TRX_STATUS_O,
  output logic NORMAL_MODE_STATUS_O,
  output logic POWER_ON_FLAG_O,
  output logic SYSTEM_EVENT_ENABLE_O,
  output logic [55:0] PN_DATA_MASK_BYTES_O,
  output logic PN_DATA_MASK_ENABLE_O,
  output logic [3:0] LIVE_STATUS_O,
  output logic [1:0] ALWAYS_LIVE_O,
  output logic [3:0] NV_CTRL_O,
  output logic [3:0] EVENT_FLAGS_O,
  output logic [3:0] EVENT_ENABLES_O,
  output logic POLARITY_CTRL_O,
  output logic ID_FORMAT_BIT_O,
  output logic [1:0] LOCK_CTRL_BITS_O,
  output logic [7:0] NV_CRC_FIELD_O,
  output logic [31:0] GENERAL_PURPOSE_MEM_O,
  output logic [28:0] FRAME_IDENTIFIER_BYTES_O,
  output logic [3:0] FRAME_LENGTH_CODE_O,
  output logic PN_CONFIG_VALID_O,
  output logic PN_FD_TOLERANCE_ENABLE_O,
  output logic WR_DISCARD_O
);
  // host write selectors
  localparam logic [3:0] SEL_MASK = 4'h0;
  localparam logic [3:0] SEL_CTRL = 4'h1;
  localparam logic [3:0] SEL_CRC = 4'h2;
  localparam logic [3:0] SEL_GPM = 4'h3;
  localparam logic [3:0] SEL_ID = 4'h4;
  localparam logic [3:0] SEL_DLC = 4'h5;
  localparam logic [3:0] SEL_EVCLR = 4'h6;
  localparam logic [3:0] SEL_SYS = 4'h7;

  mrd_pkg::mrd_mode_e mode_reg;
  mrd_pkg::mrd_mode_e mode_in;
  logic por_done_reg;
  logic [3:0] live_sync;
  logic [1:0] always_sync;
  logic trx_sync;
  logic limp_elapsed;
  logic entry;
  logic enter_off;
  logic enter_normal;
  logic enter_ot;
  logic enter_rst;
  logic wr_ok;
  logic in_normal;
  logic in_off;
  logic [1:0] rcc_inc;
  logic in_ot_or_rst;
  logic po_load;
  logic wr_mask;
  logic wr_ctrl;
  logic wr_crc;
  logic wr_gpm;
  logic wr_id;
  logic wr_dlc;
  logic wr_evclr;
  logic wr_sys;

  function automatic logic [2:0] mode_code(input mrd_pkg::mrd_mode_e m);
    case (m)
      mrd_pkg::MRD_OFF: mode_code = `MRD_MODE_OFF_VAL;
      mrd_pkg::MRD_STANDBY: mode_code = `MRD_MODE_STBY_VAL;
      mrd_pkg::MRD_NORMAL: mode_code = `MRD_MODE_NORM_VAL;
      mrd_pkg::MRD_SLEEP: mode_code = `MRD_MODE_SLEEP_VAL;
      mrd_pkg::MRD_RESET: mode_code = `MRD_MODE_RESET_VAL;
      default: mode_code = `MRD_MODE_OFF_VAL;
    endcase
  endfunction

  function automatic logic wr_hit(input logic en, input logic [3:0] sel, input logic [3:0] target);
    wr_hit = en && (sel == target);
  endfunction

  mrd_sync #(.W(7)) u_sync (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .d_i({TRX_ACTIVE_I, LIVE_STATUS_I, ALWAYS_LIVE_I}),
    .q_o({trx_sync, live_sync, always_sync})
  );

  mrd_limp_timer #(.LIMP_CYCLES(LIMP_CYCLES)) u_limp (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .run_i(in_ot_or_rst),
    .elapsed_o(limp_elapsed)
  );

  assign mode_in = mrd_pkg::mrd_mode_e'(MODE_I);
  assign in_ot_or_rst = (mode_reg == mrd_pkg::MRD_OVERTEMP) || (mode_reg == mrd_pkg::MRD_RESET);
  // one update per mode entry edge
  assign entry = (mode_in != mode_reg) && (MODE_I <= 3'h5);
  assign enter_off = entry && (mode_in == mrd_pkg::MRD_OFF);
  assign enter_normal = entry && (mode_in == mrd_pkg::MRD_NORMAL);
  assign enter_ot = entry && (mode_in == mrd_pkg::MRD_OVERTEMP);
  assign enter_rst = entry && (mode_in == mrd_pkg::MRD_RESET);
  // mode change overrides host write
  assign wr_ok = WR_EN_I && !entry;
  assign in_normal = (mode_reg == mrd_pkg::MRD_NORMAL);
  assign in_off = (mode_reg == mrd_pkg::MRD_OFF);
  assign rcc_inc = RESET_COUNTER_O + 2'h1;
  assign po_load = RESET_I || enter_off;
  // host write decode, already gated by mode entry
  assign wr_mask = wr_hit(wr_ok, WR_SEL_I, SEL_MASK);
  assign wr_ctrl = wr_hit(wr_ok, WR_SEL_I, SEL_CTRL);
  assign wr_crc = wr_hit(wr_ok, WR_SEL_I, SEL_CRC);
  assign wr_gpm = wr_hit(wr_ok, WR_SEL_I, SEL_GPM);
  assign wr_id = wr_hit(wr_ok, WR_SEL_I, SEL_ID);
  assign wr_dlc = wr_hit(wr_ok, WR_SEL_I, SEL_DLC);
  assign wr_evclr = wr_hit(wr_ok, WR_SEL_I, SEL_EVCLR);
  assign wr_sys = wr_hit(wr_ok, WR_SEL_I, SEL_SYS);

  // mode and derived fields
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      mode_reg <= mrd_pkg::MRD_OFF;
      OP_MODE_FIELD_O <= `MRD_MODE_OFF_VAL;
      RESET_COUNTER_O <= `MRD_RCC_RST;
      RESET_SOURCE_CODE_O <= `MRD_RSRC_RST;
      WATCHDOG_PERIOD_SEL_O <= `MRD_WDP_RST;
      NORMAL_MODE_STATUS_O <= 1'b1;
      WR_DISCARD_O <= 1'b0;
    end else begin
      WR_DISCARD_O <= WR_EN_I && entry;
      if (entry) begin
        mode_reg <= mode_in;
        if (mode_in != mrd_pkg::MRD_OVERTEMP) begin
          OP_MODE_FIELD_O <= mode_code(mode_in);
        end
      end
      if (enter_off) begin
        RESET_COUNTER_O <= `MRD_RCC_RST;
        RESET_SOURCE_CODE_O <= `MRD_RSRC_RST;
        WATCHDOG_PERIOD_SEL_O <= `MRD_WDP_RST;
        NORMAL_MODE_STATUS_O <= 1'b1;
      end else if (enter_rst) begin
        RESET_COUNTER_O <= rcc_inc;
        RESET_SOURCE_CODE_O <= RESET_CAUSE_I;
        WATCHDOG_PERIOD_SEL_O <= `MRD_WDP_RST;
      end else if (enter_ot) begin
        RESET_SOURCE_CODE_O <= `MRD_RSRC_OTEMP;
        WATCHDOG_PERIOD_SEL_O <= `MRD_WDP_RST;
      end else if (enter_normal) begin
        NORMAL_MODE_STATUS_O <= 1'b0;
      end else if (wr_ctrl) begin
        WATCHDOG_PERIOD_SEL_O <= WR_DATA_I[3:0];
      end
    end
  end

  // limp home request, hardware set wins over host write
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      LIMP_HOME_CTRL_O <= 1'b0;
    end else begin
      if (enter_off) begin
        LIMP_HOME_CTRL_O <= 1'b0;
      end else if (in_ot_or_rst && limp_elapsed) begin
        LIMP_HOME_CTRL_O <= 1'b1;
      end else if (enter_rst && rcc_inc == `MRD_RCC_LIMP) begin
        LIMP_HOME_CTRL_O <= 1'b1;
      end else if (wr_ctrl) begin
        LIMP_HOME_CTRL_O <= WR_DATA_I[4];
      end
    end
  end

  // live and stored status levels
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      TRX_STATUS_O <= 1'b0;
      LIVE_STATUS_O <= 4'h0;
      ALWAYS_LIVE_O <= 2'h0;
      NV_CTRL_O <= 4'h0;
    end else begin
      TRX_STATUS_O <= in_normal && !entry && trx_sync;
      LIVE_STATUS_O <= (in_off || enter_off) ? 4'h0 : live_sync;
      ALWAYS_LIVE_O <= always_sync;
      NV_CTRL_O <= NV_CTRL_I;
    end
  end

  // system event bits, off entry acts as power-on
  always_ff @(posedge MCLK_I) begin
    if (po_load) begin
      POWER_ON_FLAG_O <= 1'b1;
      SYSTEM_EVENT_ENABLE_O <= 1'b1;
    end else begin
      if (wr_evclr) begin
        POWER_ON_FLAG_O <= POWER_ON_FLAG_O & ~WR_DATA_I[4];
      end
      if (wr_sys) begin
        SYSTEM_EVENT_ENABLE_O <= WR_DATA_I[0];
      end
    end
  end

  // partial networking mask and config
  always_ff @(posedge MCLK_I) begin
    if (po_load) begin
      PN_DATA_MASK_BYTES_O <= `MRD_DM_RST;
      PN_DATA_MASK_ENABLE_O <= 1'b1;
      PN_CONFIG_VALID_O <= 1'b0;
      PN_FD_TOLERANCE_ENABLE_O <= 1'b0;
    end else if (wr_mask) begin
      PN_DATA_MASK_BYTES_O <= WR_DATA_I[55:0];
      PN_DATA_MASK_ENABLE_O <= WR_DATA_I[56];
      PN_CONFIG_VALID_O <= WR_DATA_I[57];
      PN_FD_TOLERANCE_ENABLE_O <= WR_DATA_I[58];
    end
  end

  // event flags, enables, polarity and lock
  always_ff @(posedge MCLK_I) begin
    if (po_load) begin
      EVENT_FLAGS_O <= 4'h0;
      EVENT_ENABLES_O <= 4'h0;
      POLARITY_CTRL_O <= 1'b0;
      LOCK_CTRL_BITS_O <= 2'h0;
    end else begin
      if (wr_evclr) begin
        EVENT_FLAGS_O <= EVENT_FLAGS_O & ~WR_DATA_I[3:0];
      end
      if (wr_sys) begin
        EVENT_ENABLES_O <= WR_DATA_I[4:1];
        POLARITY_CTRL_O <= WR_DATA_I[5];
        LOCK_CTRL_BITS_O <= WR_DATA_I[7:6];
      end
    end
  end

  // crc control and general purpose memory
  always_ff @(posedge MCLK_I) begin
    if (po_load) begin
      NV_CRC_FIELD_O <= `MRD_CRC_RST;
      GENERAL_PURPOSE_MEM_O <= `MRD_GPM_RST;
    end else begin
      if (wr_crc) begin
        NV_CRC_FIELD_O <= WR_DATA_I[7:0];
      end
      if (wr_gpm) begin
        GENERAL_PURPOSE_MEM_O <= WR_DATA_I[31:0];
      end
    end
  end

  // wake frame identifier, format and length
  always_ff @(posedge MCLK_I) begin
    if (po_load) begin
      FRAME_IDENTIFIER_BYTES_O <= `MRD_ID_RST;
      ID_FORMAT_BIT_O <= 1'b0;
      FRAME_LENGTH_CODE_O <= `MRD_DLC_RST;
    end else begin
      if (wr_id) begin
        FRAME_IDENTIFIER_BYTES_O <= WR_DATA_I[28:0];
        ID_FORMAT_BIT_O <= WR_DATA_I[29];
      end
      if (wr_dlc) begin
        FRAME_LENGTH_CODE_O <= WR_DATA_I[3:0];
      end
    end
  end
endmodule

// *** dv/mrd_regs_properties.sv ***
/*
  Checker for mode entry updates of the register default block.
  Assumes it is bound to mrd_regs and sees only its ports.
*/
`timescale 1ns/1ps
module mrd_regs_props (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic [2:0] MODE_I,
  input wire logic [4:0] RESET_CAUSE_I,
  input wire logic WR_EN_I,
  input wire logic [2:0] OP_MODE_FIELD_O,
  input wire logic [1:0] RESET_COUNTER_O,
  input wire logic [4:0] RESET_SOURCE_CODE_O,
  input wire logic [3:0] WATCHDOG_PERIOD_SEL_O,
  input wire logic LIMP_HOME_CTRL_O,
  input wire logic TRX_STATUS_O,
  input wire logic NORMAL_MODE_STATUS_O,
  input wire logic WR_DISCARD_O
);
  logic [2:0] cur_reg;
  wire entry = (MODE_I <= 3'h5) && (MODE_I != cur_reg);
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) cur_reg <= 3'h0;
    else if (entry) cur_reg <= MODE_I;
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  sequence s_rst_entry;
    entry && (MODE_I == 3'h5);
  endsequence
  sequence s_norm_entry;
    entry && (MODE_I == 3'h2);
  endsequence
  AST_NORM_FIELD: assert property (s_norm_entry |=> OP_MODE_FIELD_O == 3'h7) else $error("normal field");
  AST_SLEEP_FIELD: assert property (entry && MODE_I == 3'h3 |=> OP_MODE_FIELD_O == 3'h1) else $error("sleep field");
  AST_RCC_INC: assert property (s_rst_entry |=> RESET_COUNTER_O == $past(RESET_COUNTER_O) + 2'h1) else $error("rcc");
  AST_RSRC_CAUSE: assert property (s_rst_entry |=> RESET_SOURCE_CODE_O == $past(RESET_CAUSE_I)) else $error("src");
  AST_OTEMP: assert property (entry && MODE_I == 3'h4 |=>
    RESET_SOURCE_CODE_O == 5'h12 && WATCHDOG_PERIOD_SEL_O == 4'h4) else $error("otemp");
  AST_LIMP_RCC: assert property (s_rst_entry ##0 RESET_COUNTER_O == 2'h2 |=> LIMP_HOME_CTRL_O) else $error("limp");
  AST_TRX_ZERO: assert property (cur_reg != 3'h2 |-> !TRX_STATUS_O) else $error("trx");
  AST_NMS_CLR: assert property (s_norm_entry |=> !NORMAL_MODE_STATUS_O) else $error("nms");
  AST_DISCARD: assert property (WR_EN_I && entry |=> WR_DISCARD_O) else $error("discard");
endmodule
bind mrd_regs mrd_regs_props i_props (.MCLK_I, .RESET_I, .MODE_I, .RESET_CAUSE_I, .WR_EN_I, .OP_MODE_FIELD_O,
  .RESET_COUNTER_O, .RESET_SOURCE_CODE_O, .WATCHDOG_PERIOD_SEL_O, .LIMP_HOME_CTRL_O, .TRX_STATUS_O,
  .NORMAL_MODE_STATUS_O, .WR_DISCARD_O);

// *** dv/mrd_host.sv ***
/*
  Host partner: issues register writes as one-cycle strobes.
  Assumes the bench calls write() and the design samples on the rising edge.
*/
`timescale 1ns/1ps
module mrd_host (
  input wire logic clk_i,
  output logic wr_en_o,
  output logic [3:0] wr_sel_o,
  output logic [63:0] wr_data_o
);
  initial begin
    wr_en_o = 1'b0;
    wr_sel_o = 4'h0;
    wr_data_o = 64'h0;
  end
  // qualifiers held through the sampling edge, data scrambled after
  task automatic write(input logic [3:0] sel, input logic [63:0] data);
    @(negedge clk_i);
    wr_en_o = 1'b1;
    wr_sel_o = sel;
    wr_data_o = data;
    @(negedge clk_i);
    wr_en_o = 1'b0;
    wr_data_o = ~data;
  endtask
endmodule

// *** dv/testbench.sv ***
/*
  Self-checking bench for mrd_regs with an integer reference model.
  Assumes the host partner and the bound checker.
*/
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] mode = 3'h0;
  logic [4:0] cause = 5'h0;
  logic trx = 1'b1;
  logic [3:0] live = 4'h0;
  logic [1:0] alive = 2'h0;
  logic [3:0] nv = 4'h0;
  logic wr_en, limp, trxs, normal_mode_status, po, system_event_enable, dme, pol, idf, cfg, fdt, disc;
  logic [3:0] wr_sel, wdp, lso, nvo, evf, eve, frame_length_code;
  logic [63:0] wr_data;
  logic [2:0] fld;
  logic [1:0] reset_counter, alo, lk;
  logic [4:0] reset_source_code;
  logic [55:0] dm;
  logic [7:0] crc;
  logic [31:0] gpm, d;
  logic [28:0] fid;
  int n_mismatch = 0, checks_done = 0;
  int m_mode = 0, m_fld = 4, m_rcc = 0, m_rss = 0, m_wdp = 4, m_limp = 0, m_nms = 1;
  logic [57:0] m_kept = {2'h3, 56'hff_ffff_ffff_ffff};
  int walk[$] = '{1, 2, 3, 5, 2, 5, 6, 1, 4, 1, 5, 0, 5, 4, 5, 3};
  initial forever #5 clk = ~clk;
  mrd_host i_host (.clk_i(clk), .wr_en_o(wr_en), .wr_sel_o(wr_sel), .wr_data_o(wr_data));
  mrd_regs #(.LIMP_CYCLES(20)) i_dut (.MCLK_I(clk), .RESET_I(rst), .MODE_I(mode), .RESET_CAUSE_I(cause),
    .TRX_ACTIVE_I(trx), .LIVE_STATUS_I(live), .ALWAYS_LIVE_I(alive), .NV_CTRL_I(nv), .WR_EN_I(wr_en),
    .WR_SEL_I(wr_sel), .WR_DATA_I(wr_data), .OP_MODE_FIELD_O(fld), .RESET_COUNTER_O(reset_counter), .RESET_SOURCE_CODE_O(reset_source_code),
    .WATCHDOG_PERIOD_SEL_O(wdp), .LIMP_HOME_CTRL_O(limp), .TRX_STATUS_O(trxs), .NORMAL_MODE_STATUS_O(normal_mode_status),
    .POWER_ON_FLAG_O(po), .SYSTEM_EVENT_ENABLE_O(system_event_enable), .PN_DATA_MASK_BYTES_O(dm), .PN_DATA_MASK_ENABLE_O(dme),
    .LIVE_STATUS_O(lso), .ALWAYS_LIVE_O(alo), .NV_CTRL_O(nvo), .EVENT_FLAGS_O(evf), .EVENT_ENABLES_O(eve),
    .POLARITY_CTRL_O(pol), .ID_FORMAT_BIT_O(idf), .LOCK_CTRL_BITS_O(lk), .NV_CRC_FIELD_O(crc),
    .GENERAL_PURPOSE_MEM_O(gpm), .FRAME_IDENTIFIER_BYTES_O(fid), .FRAME_LENGTH_CODE_O(frame_length_code),
    .PN_CONFIG_VALID_O(cfg), .PN_FD_TOLERANCE_ENABLE_O(fdt), .WR_DISCARD_O(disc));
  task automatic cmp(input string nm, input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic enter(input int md);
    @(negedge clk);
    mode = md[2:0];
    cause = 5'($urandom);
    @(negedge clk);
    if (md <= 5 && md != m_mode) begin
      case (md)
        0: begin m_fld = 4; m_rcc = 0; m_rss = 0; m_wdp = 4; m_limp = 0; m_nms = 1; end
        1: m_fld = 4;
        2: begin m_fld = 7; m_nms = 0; end
        3: m_fld = 1;
        4: begin m_rss = 5'h12; m_wdp = 4; end
        default: begin
          m_fld = 4; m_rcc = (m_rcc + 1) % 4; m_rss = cause; m_wdp = 4;
          if (m_rcc == 3) m_limp = 1;
        end
      endcase
      if (md == 0) m_kept = {2'h3, 56'hff_ffff_ffff_ffff};
      m_mode = md;
    end
    cmp("mode_regs", {fld, reset_counter, reset_source_code, wdp, limp, normal_mode_status}, {m_fld[2:0], m_rcc[1:0], m_rss[4:0], m_wdp[3:0], m_limp[0], m_nms[0]});
    cmp("kept", {system_event_enable, dme, dm}, m_kept);
    if (m_mode != 2) cmp("trx", trxs, 1'b0);
  endtask
  initial begin
    #50us;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h5012));
    repeat (12) @(negedge clk);
    rst = 1'b0;
    live = 4'($urandom);
    alive = 2'($urandom);
    nv = 4'($urandom);
    repeat (4) @(negedge clk);
    cmp("defaults", {po, evf, eve, pol, idf, lk, crc, fid, frame_length_code, cfg, fdt, lso, gpm[0]}, 64'h1000_0000_0000_0000);
    cmp("gpm", gpm, 64'h0);
    cmp("always_live", alo, alive);
    cmp("nv_ctrl", nvo, nv);
    enter(0);
    $display("test defaults done");
    d = $urandom;
    i_host.write(4'h1, {59'h0, 1'b0, d[3:0]});
    m_wdp = d[3:0];
    foreach (walk[i]) enter(walk[i]);
    cmp("live", lso, live);
    $display("test mode walk done");
    i_host.write(4'h6, 64'h10);
    cmp("po_clear", po, 1'b0);
    enter(0);
    cmp("po_set", po, 1'b1);
    enter(4);
    repeat (25) @(negedge clk);
    m_limp = 1;
    enter(1);
    $display("test limp delay done");
    fork
      i_host.write(4'h1, 64'h9);
      enter(2);
    join
    cmp("discard", disc, 1'b1);
    d = $urandom;
    i_host.write(4'h1, {59'h0, d[4:0]});
    cmp("wdp_wr", {limp, wdp}, d[4:0]);
    m_wdp = d[3:0];
    m_limp = d[4];
    repeat (3) @(negedge clk);
    cmp("trx_normal", trxs, trx);
    trx = 1'b0;
    repeat (4) @(negedge clk);
    cmp("trx_low", trxs, 1'b0);
    $display("test discard done");
    d = $urandom;
    i_host.write(4'h2, {56'h0, d[7:0]});
    i_host.write(4'h3, {32'h0, d});
    i_host.write(4'h4, {34'h0, d[29:0]});
    i_host.write(4'h5, {60'h0, d[3:0]});
    i_host.write(4'h7, {56'h0, d[7:0]});
    i_host.write(4'h0, {5'h0, d[2:0], d[23:0], d});
    m_kept = {d[0], d[0], d[23:0], d};
    enter(5);
    enter(4);
    cmp("kept_nv", {crc, gpm, frame_length_code}, {d[7:0], d, d[3:0]});
    cmp("kept_id", {idf, fid, eve, pol, lk}, {d[29:0], d[4:1], d[5], d[7:6]});
    cmp("kept_pn", {fdt, cfg}, d[2:1]);
    enter(0);
    cmp("off_clear", {crc, fid, frame_length_code, eve, pol, idf, lk, cfg, fdt}, 64'h0);
    cmp("off_gpm", gpm, 64'h0);
    $display("test kept fields done");
    end_of_test();
  end
endmodule
